// File: dv/irq_source.sv
// peripheral model: raises interrupt request pulses, promptly or after a delay
// assumes the bench pulses i_fire for one cycle of i_mclk
`timescale 1ns/1ps
module irq_source #(
    parameter int NUM_IRQ = 8
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // bench commands
    input wire logic [NUM_IRQ-1:0] i_fire,
    input wire logic [3:0] i_delay,
    // request lines toward the core
    output logic [NUM_IRQ-1:0] o_irq
);
    logic [NUM_IRQ-1:0] hold_r;  // requests waiting out their delay
    logic [3:0] cnt_r;  // cycles left before they go out
    // lines idle low, each request is a one-cycle pulse
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            hold_r <= '0;
            cnt_r <= 4'h0;
            o_irq <= '0;
        end else begin
            o_irq <= '0;
            if (|i_fire) begin
                hold_r <= i_fire;
                cnt_r <= i_delay;
            end else if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end else begin
                o_irq <= hold_r;
                hold_r <= '0;
            end
        end
    end
endmodule : irq_source

// File: dv/tb_processor_exception_model.sv
// self-checking bench for the exception unit
// assumes exc_unit with eight external interrupts fed by irq_source
`timescale 1ns/1ps
module tb_processor_exception_model;
    import exc_pkg::*;
    localparam int NI = 8;
    localparam int NW = $clog2(NI + 16);
    // stimulus toward the unit
    logic i_mclk = 0, i_reset = 1, i_privileged = 1, i_drop_priv = 0, trap = 0;
    logic i_en_wr = 0, i_en_val = 0, i_prio_wr = 0, i_enter = 0, i_return = 0;
    logic [NW-1:0] i_en_num = '0, i_prio_num = '0, i_ret_num = '0;
    logic [3:0] i_prio_val = '0, pdelay = '0;
    logic [15:0] fl = '0;  // one line per event source
    logic [NI-1:0] pfire = '0, i_irq;
    // unit outputs
    logic o_take_valid, o_take_async, o_fetch_valid, o_handler_mode, o_privileged;
    logic [NW-1:0] o_take_num, o_exception_number_status_register;
    logic [31:0] o_take_vec, o_fetch_addr;
    logic [NI+15:0] o_pending, o_active;
    int n_mismatch = 0, n_tests = 0;
    // expected number and async flag per event line, configurable sources
    int xn[16] = '{4, 4, 5, 5, 6, 6, 6, 6, 6, 11, 14, 15, 15, 3, 2, 17};
    logic [15:0] xa = 16'hDC08;
    int en[8] = '{4, 5, 6, 11, 14, 15, 16, 17};
    exc_unit #(.NUM_IRQ(NI)) u_exc_unit (
        .i_prot_viol(fl[0]), .i_execute_never_fetch(fl[1]), .i_bus_err_precise(fl[2]),
        .i_bus_err_imprecise(fl[3]), .i_undef_instr(fl[4]), .i_illegal_unaligned(fl[5]),
        .i_invalid_state(fl[6]), .i_unaligned_access(fl[7]), .i_div_zero(fl[8]),
        .i_supervisor_call(fl[9]), .i_pendable_service_set(fl[10]), .i_tick_zero(fl[11]),
        .i_tick_set(fl[12]), .i_proc_err(fl[13]), .i_nmi_req(fl[14]),
        .i_irq_sw_set({6'h00, fl[15], 1'b0}), .i_trap_unaligned(trap),
        .i_trap_div_zero(trap), .i_mclk, .i_reset, .i_irq, .i_privileged, .i_drop_priv,
        .i_en_wr, .i_en_num, .i_en_val, .i_prio_wr, .i_prio_num, .i_prio_val,
        .i_enter, .i_return, .i_ret_num, .o_take_valid, .o_take_num, .o_take_vec,
        .o_take_async, .o_exception_number_status_register, .o_pending, .o_active,
        .o_fetch_valid, .o_fetch_addr, .o_handler_mode, .o_privileged);
    irq_source #(.NUM_IRQ(NI)) u_irq_source (.i_mclk(i_mclk), .i_reset(i_reset),
        .i_fire(pfire), .i_delay(pdelay), .o_irq(i_irq));
    always #20 i_mclk = ~i_mclk;
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one configuration write, enable or priority
    task cfg(input logic pw, input int num, input logic [3:0] v);
        @(posedge i_mclk);
        i_prio_wr <= pw;
        i_en_wr <= !pw;
        i_prio_num <= NW'(num);
        i_en_num <= NW'(num);
        i_prio_val <= v;
        i_en_val <= v[0];
        @(posedge i_mclk);
        i_prio_wr <= 1'b0;
        i_en_wr <= 1'b0;
    endtask : cfg
    task hit(input logic [15:0] m);
        @(posedge i_mclk);
        fl <= m;
        @(posedge i_mclk);
        fl <= '0;
    endtask : hit
    task fire(input logic [NI-1:0] m, input logic [3:0] d);
        @(posedge i_mclk);
        pfire <= m;
        pdelay <= d;
        @(posedge i_mclk);
        pfire <= '0;
    endtask : fire
    // wait for the offer, check it, accept it
    task enter_exc(input int num, input logic asy);
        for (int i = 0; i < 20 && o_take_valid !== 1'b1; i++) begin
            @(posedge i_mclk);
            #1;
        end
        chk("take_num", num, o_take_num);
        chk("take_vec", num * 4, o_take_vec);
        chk("take_async", asy, o_take_async);
        chk("pend_only", 2'b10, {o_pending[num], o_active[num]});
        @(posedge i_mclk);
        i_enter <= 1'b1;
        @(posedge i_mclk);
        i_enter <= 1'b0;
        #1 chk("act_only", 2'b01, {o_pending[num], o_active[num]});
        chk("handler_mode", 1, o_handler_mode);
        @(posedge i_mclk);
        #1 chk("status", num, o_exception_number_status_register);
    endtask : enter_exc
    task ret(input int num);
        @(posedge i_mclk);
        i_return <= 1'b1;
        i_ret_num <= NW'(num);
        @(posedge i_mclk);
        i_return <= 1'b0;
        #1 chk("returned", 0, o_active[num]);
        chk("reserved", 0, (o_active | o_pending) & 24'h00_3780);
    endtask : ret
    task t_reset();
        repeat (4) @(posedge i_mclk);
        #1 chk("priv_in_reset", 1, o_privileged);
        chk("active_in_reset", 0, o_active);
        chk("fetch_addr", 32'h0000_0004, o_fetch_addr);
        repeat (4) @(posedge i_mclk);
        i_reset <= 1'b0;
        @(posedge i_mclk);
        #1 chk("fetch_valid", 1, o_fetch_valid);
    endtask : t_reset
    task t_trap_off();
        hit(16'h0180);
        repeat (4) @(posedge i_mclk);
        #1 chk("no_trap", 0, o_pending);
        hit(16'h0200);
        enter_exc(3, 0);
        ret(3);
    endtask : t_trap_off
    task t_irq_nest();
        foreach (en[k]) cfg(0, en[k], 4'h1);
        i_privileged <= 1'b0;
        cfg(0, 16, 4'h0);
        i_privileged <= 1'b1;
        fire(8'h01, 4'h0);
        enter_exc(16, 1);
        fire(8'h01, 4'h3);
        repeat (8) @(posedge i_mclk);
        #1 chk("act_and_pend", 2'b11, {o_pending[16], o_active[16]});
        hit(16'h4000);
        enter_exc(2, 1);
        chk("nested", 2'b11, {o_active[2], o_active[16]});
        ret(2);
        ret(16);
        enter_exc(16, 1);
        ret(16);
    endtask : t_irq_nest
    task t_all_sources();
        @(posedge i_mclk);
        trap <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            hit(16'h0001 << k);
            enter_exc(xn[k], xa[k]);
            ret(xn[k]);
        end
    endtask : t_all_sources
    task t_priority();
        hit(16'h0C00);
        enter_exc(14, 1);
        ret(14);
        enter_exc(15, 1);
        ret(15);
        cfg(1, 16, 4'h3);
        fire(8'h03, 4'h0);
        enter_exc(17, 1);
        ret(17);
        enter_exc(16, 1);
        ret(16);
    endtask : t_priority
    // thread code may give up privilege; the flag must follow
    task t_drop_priv();
        chk("thread_mode", 0, o_handler_mode);
        @(posedge i_mclk);
        i_drop_priv <= 1'b1;
        @(posedge i_mclk);
        i_drop_priv <= 1'b0;
        #1 chk("priv_dropped", 0, o_privileged);
    endtask : t_drop_priv
    task test_done();
        if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    initial begin
        t_reset();
        t_trap_off();
        t_irq_nest();
        t_all_sources();
        t_priority();
        t_drop_priv();
        test_done();
    end
    // cut a hang short well past the expected run length
    initial begin
        repeat (3000) @(posedge i_mclk);
        n_mismatch++;
        test_done();
    end
endmodule : tb_processor_exception_model

// File: shared/exc_arb_if.sv
// carries requests and current activity to the arbiter and its choice back
// assumes both ends share the unit's clock; purely combinational between them
`timescale 1ns/1ps
interface exc_arb_if #(parameter int NUM = 24);
    logic [NUM-1:0] req;              // pending and eligible
    logic [NUM-1:0] act;              // active sources
    logic [NUM-1:0][5:0] prio;        // signed priority per source
    logic win_valid;                  // some request present
    logic [$clog2(NUM)-1:0] win_num;  // most urgent request
    logic [5:0] win_prio;             // its priority
    logic [5:0] cur_prio;             // most urgent active level
    logic [$clog2(NUM)-1:0] cur_num;  // current exception, 0 in thread
    modport unit (output req, act, prio, input win_valid, win_num, win_prio, cur_prio, cur_num);
    modport arb (input req, act, prio, output win_valid, win_num, win_prio, cur_prio, cur_num);
endinterface : exc_arb_if

// File: shared/exc_pkg.sv
// holds exception numbers, fixed priorities, the reset vector and phases of the exception unit
// assumes a core that fetches vectors itself and acknowledges entry and return
package exc_pkg;
    // exception numbers
    localparam int EXC_RESET = 1;
    localparam int EXC_NMI = 2;
    localparam int EXC_HARD = 3;
    localparam int EXC_MEM = 4;
    localparam int EXC_BUS = 5;
    localparam int EXC_USAGE = 6;
    localparam int EXC_SUPER_CALL = 11;
    localparam int EXC_PENDSRV = 14;
    localparam int EXC_TICK = 15;
    localparam int EXC_IRQ0 = 16;
    // default and largest count of external interrupts
    localparam int NUM_IRQ_DEF = 8;
    localparam int NUM_IRQ_MAX = 240;
    // priority width, fixed priorities and the level of thread code
    localparam int PRIO_W = 6;
    localparam int CFG_PRIO_W = 4;
    localparam logic signed [PRIO_W-1:0] PRIO_RESET = -6'sh03;
    localparam logic signed [PRIO_W-1:0] PRIO_NMI = -6'sh02;
    localparam logic signed [PRIO_W-1:0] PRIO_HARD = -6'sh01;
    localparam logic signed [PRIO_W-1:0] PRIO_THREAD = 6'sh10;
    // vector of the reset entry
    localparam logic [31:0] VEC_RESET = 32'h0000_0004;
    // reset value of configurable enables and priorities
    localparam logic EN_RESET = 1'b0;
    localparam logic [CFG_PRIO_W-1:0] PRIO_CFG_RESET = 4'h0;

    // one-hot phases of the unit
    typedef enum logic [1:0] {
        PH_FETCH = 2'b01,
        PH_RUN = 2'b10
    } phase_t;

    // numbers that never carry an exception
    function automatic logic is_reserved(input int n);
        is_reserved = (n == 0) || (n >= 7 && n <= 10) || (n == 12) || (n == 13);
    endfunction : is_reserved

    // priority cannot be configured or disabled
    function automatic logic is_fixed(input int n);
        is_fixed = (n == EXC_RESET) || (n == EXC_NMI) || (n == EXC_HARD);
    endfunction : is_fixed

    // taken asynchronously to instruction execution
    function automatic logic is_async(input int n);
        is_async = (n == EXC_NMI) || (n == EXC_PENDSRV) || (n >= EXC_TICK);
    endfunction : is_async
endpackage : exc_pkg

// File: src/exc_arbiter.sv
// picks the most urgent pending request and the current active level
// assumes priorities arrive as signed values, lower meaning more urgent
`timescale 1ns/1ps
module exc_arbiter
    import exc_pkg::*;
#(
    parameter int NUM = 24
) (
    // arbitration port
    exc_arb_if.arb a
);
    localparam int NW = $clog2(NUM);

    // state of this module: none, only the scan result
    typedef struct packed {
        logic win_valid;
        logic [NW-1:0] win_num;
        logic signed [PRIO_W-1:0] win_prio;
        logic signed [PRIO_W-1:0] cur_prio;
        logic [NW-1:0] cur_num;
    } scan_t;

    scan_t s;

    // scan from high numbers down so equal priority favours the lower number
    always_comb begin
        s = '0;
        s.win_prio = PRIO_THREAD;
        s.cur_prio = PRIO_THREAD;
        for (int i = NUM - 1; i >= 1; i--) begin
            // lower value is more urgent; ties go to lower number
            if (a.req[i] && ($signed(a.prio[i]) <= s.win_prio)) begin
                s.win_valid = 1'b1;
                s.win_num = NW'(i);
                s.win_prio = $signed(a.prio[i]);
            end
            // the most urgent active handler is the one running
            if (a.act[i] && ($signed(a.prio[i]) <= s.cur_prio)) begin
                s.cur_num = NW'(i);
                s.cur_prio = $signed(a.prio[i]);
            end
        end
    end

    // drive the choice back
    assign a.win_valid = s.win_valid;
    assign a.win_num = s.win_num;
    assign a.win_prio = s.win_prio;
    assign a.cur_prio = s.cur_prio;
    assign a.cur_num = s.cur_num;
endmodule : exc_arbiter

// File: src/exc_unit.sv
// holds the exception state machine of the core: pending, active, enables, priorities
// assumes the core acknowledges entry and return with one-cycle pulses on i_mclk
`timescale 1ns/1ps

module exc_unit
    import exc_pkg::*;
#(
    parameter int NUM_IRQ = NUM_IRQ_DEF
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // fault and event sources
    input wire logic i_nmi_req,
    input wire logic i_proc_err,
    input wire logic i_prot_viol,
    input wire logic i_execute_never_fetch,
    input wire logic i_bus_err_precise,
    input wire logic i_bus_err_imprecise,
    input wire logic i_undef_instr,
    input wire logic i_illegal_unaligned,
    input wire logic i_invalid_state,
    input wire logic i_unaligned_access,
    input wire logic i_div_zero,
    input wire logic i_supervisor_call,
    input wire logic i_pendable_service_set,
    input wire logic i_tick_zero,
    input wire logic i_tick_set,
    input wire logic [NUM_IRQ-1:0] i_irq,
    input wire logic [NUM_IRQ-1:0] i_irq_sw_set,
    // trap configuration
    input wire logic i_trap_unaligned,
    input wire logic i_trap_div_zero,
    // enable and priority writes
    input wire logic i_privileged,
    input wire logic i_en_wr,
    input wire logic [$clog2(NUM_IRQ+16)-1:0] i_en_num,
    input wire logic i_en_val,
    input wire logic i_prio_wr,
    input wire logic [$clog2(NUM_IRQ+16)-1:0] i_prio_num,
    input wire logic [CFG_PRIO_W-1:0] i_prio_val,
    input wire logic i_drop_priv,
    // core handshake
    input wire logic i_enter,
    input wire logic i_return,
    input wire logic [$clog2(NUM_IRQ+16)-1:0] i_ret_num,
    // exception request toward the core
    output logic o_take_valid,
    output logic [$clog2(NUM_IRQ+16)-1:0] o_take_num,
    output logic [31:0] o_take_vec,
    output logic o_take_async,
    // status
    output logic [$clog2(NUM_IRQ+16)-1:0] o_exception_number_status_register,
    output logic [NUM_IRQ+15:0] o_pending,
    output logic [NUM_IRQ+15:0] o_active,
    output logic o_fetch_valid,
    output logic [31:0] o_fetch_addr,
    output logic o_handler_mode,
    output logic o_privileged
);
    localparam int NUM = NUM_IRQ + 16;
    localparam int NW = $clog2(NUM);

    // refuse counts the logic cannot serve
    if (NUM_IRQ < 1 || NUM_IRQ > NUM_IRQ_MAX) begin : g_chk
        $error("exc_unit: NUM_IRQ out of range");
    end

    // whole state of the unit
    typedef struct packed {
        phase_t phase;                       // fetch after reset, then run
        logic [NUM-1:0] pend;                // pending bits
        logic [NUM-1:0] act;                 // active bits
        logic [NUM-1:0] en;                  // enables of configurable sources
        logic [NUM-1:0][CFG_PRIO_W-1:0] prio; // configured priorities
        logic bus_async;                     // pending bus fault is imprecise
        logic take_valid;
        logic [NW-1:0] take_num;
        logic [31:0] take_vec;
        logic take_async;
        logic [NW-1:0] exc_number;
        logic fetch_valid;
        logic handler_mode;
        logic privileged;
    } state_t;

    state_t r;
    state_t n;
    exc_arb_if #(.NUM(NUM)) arb_bus ();

    // arbiter over the pending set
    exc_arbiter #(.NUM(NUM)) u_arb (
        .a(arb_bus)
    );

    // effective signed priority of one source
    function automatic logic signed [PRIO_W-1:0] prio_of(input int i, input state_t s);
        if (i == EXC_RESET) begin
            prio_of = PRIO_RESET;
        end else if (i == EXC_NMI) begin
            prio_of = PRIO_NMI;
        end else if (i == EXC_HARD) begin
            prio_of = PRIO_HARD;
        end else begin
            prio_of = $signed({2'b00, s.prio[i]});
        end
    endfunction : prio_of

    // vector offset is four bytes per exception number
    function automatic logic [31:0] vec_of(input logic [NW-1:0] num);
        vec_of = {{(30 - NW){1'b0}}, num, 2'b00};
    endfunction : vec_of

    // feed the arbiter: only eligible pending sources compete
    always_comb begin
        for (int i = 0; i < NUM; i++) begin
            arb_bus.prio[i] = prio_of(i, r);
            arb_bus.req[i] = r.pend[i] && !is_reserved(i)
                && (is_fixed(i) || r.en[i]);
            arb_bus.act[i] = r.act[i];
        end
    end

    logic [NUM-1:0] evt;  // sources raised this cycle
    logic [NUM-1:0] pclr; // pending bits cleared by entry
    logic [NUM-1:0] aclr; // active bits cleared by return
    logic enter_now;
    logic bad_return;
    logic usage_evt;

    // next state
    always_comb begin
        n = r;
        evt = '0;
        pclr = '0;
        aclr = '0;
        enter_now = i_enter && r.take_valid && (r.phase == PH_RUN);
        bad_return = i_return && !r.act[i_ret_num];
        usage_evt = i_undef_instr || i_illegal_unaligned || i_invalid_state || bad_return
            || (i_unaligned_access && i_trap_unaligned)
            || (i_div_zero && i_trap_div_zero);
        n.fetch_valid = 1'b0;
        case (r.phase)
            PH_FETCH: begin
                // one pulse asking for the reset vector, privileged thread
                n.fetch_valid = 1'b1;
                n.phase = PH_RUN;
            end
            PH_RUN: begin
                // nmi cannot be masked
                evt[EXC_NMI] = i_nmi_req;
                evt[EXC_HARD] = i_proc_err;
                // synchronous faults: taken if enabled and able to preempt, else hard
                if (i_prot_viol || i_execute_never_fetch) begin
                    if (r.en[EXC_MEM] && prio_of(EXC_MEM, r) < $signed(arb_bus.cur_prio)) begin
                        evt[EXC_MEM] = 1'b1;
                    end else begin
                        evt[EXC_HARD] = 1'b1;
                    end
                end
                if (i_bus_err_precise) begin
                    if (r.en[EXC_BUS] && prio_of(EXC_BUS, r) < $signed(arb_bus.cur_prio)) begin
                        evt[EXC_BUS] = 1'b1;
                    end else begin
                        evt[EXC_HARD] = 1'b1;
                    end
                end
                if (i_bus_err_imprecise) begin
                    // imprecise errors wait for their turn
                    if (r.en[EXC_BUS]) begin
                        evt[EXC_BUS] = 1'b1;
                        n.bus_async = 1'b1;
                    end else begin
                        evt[EXC_HARD] = 1'b1;
                    end
                end
                if (usage_evt) begin
                    if (r.en[EXC_USAGE] && prio_of(EXC_USAGE, r) < $signed(arb_bus.cur_prio)) begin
                        evt[EXC_USAGE] = 1'b1;
                    end else begin
                        evt[EXC_HARD] = 1'b1;
                    end
                end
                if (i_supervisor_call) begin
                    if (r.en[EXC_SUPER_CALL]
                        && prio_of(EXC_SUPER_CALL, r) < $signed(arb_bus.cur_prio)) begin
                        evt[EXC_SUPER_CALL] = 1'b1;
                    end else begin
                        evt[EXC_HARD] = 1'b1;
                    end
                end
                evt[EXC_PENDSRV] = i_pendable_service_set;
                evt[EXC_TICK] = i_tick_zero || i_tick_set;
                evt[NUM-1:EXC_IRQ0] = i_irq | i_irq_sw_set;
                // entry: pending moves to active, others stay active
                if (enter_now) begin
                    pclr[r.take_num] = 1'b1;
                    if (int'(r.take_num) == EXC_BUS) begin
                        // an imprecise error landing at entry keeps its flag: set wins
                        n.bus_async = i_bus_err_imprecise && r.en[EXC_BUS];
                    end
                end
                // return retires one active handler
                if (i_return && !bad_return) begin
                    aclr[i_ret_num] = 1'b1;
                end
            end
            default: begin
                n.phase = PH_FETCH;
            end
        endcase
        // a new request wins over the clear, giving active and pending
        n.pend = ((r.pend & ~pclr) | evt) & ~NUM'(1 << EXC_RESET);
        n.act = (r.act & ~aclr) | pclr;
        // enable writes only from privileged code, only configurable sources
        if (i_en_wr && i_privileged && !is_fixed(int'(i_en_num))
            && !is_reserved(int'(i_en_num)) && int'(i_en_num) < NUM) begin
            n.en[i_en_num] = i_en_val;
        end
        if (i_prio_wr && i_privileged && !is_fixed(int'(i_prio_num)) && int'(i_prio_num) < NUM) begin
            n.prio[i_prio_num] = i_prio_val;
        end
        // offer the winner only if it preempts the running level
        n.take_valid = (r.phase == PH_RUN) && arb_bus.win_valid && !enter_now && !i_return
            && ($signed(arb_bus.win_prio) < $signed(arb_bus.cur_prio));
        n.take_num = arb_bus.win_num;
        n.take_vec = vec_of(arb_bus.win_num);
        n.take_async = is_async(int'(arb_bus.win_num))
            || (int'(arb_bus.win_num) == EXC_BUS && r.bus_async);
        // status shows the exception number, not a shifted interrupt index
        n.exc_number = arb_bus.cur_num;
        n.handler_mode = |n.act;
        if (i_drop_priv && !r.handler_mode) begin
            n.privileged = 1'b0;
        end
    end

    // register the state; reset halts everything at once
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            r <= '0;
            r.phase <= PH_FETCH;
            r.privileged <= 1'b1;
            r.en <= {NUM{EN_RESET}};
            r.prio <= {NUM{PRIO_CFG_RESET}};
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state flops, the fetch address a constant
    assign o_take_valid = r.take_valid;
    assign o_take_num = r.take_num;
    assign o_take_vec = r.take_vec;
    assign o_take_async = r.take_async;
    assign o_exception_number_status_register = r.exc_number;
    assign o_pending = r.pend;
    assign o_active = r.act;
    assign o_fetch_valid = r.fetch_valid;
    assign o_fetch_addr = VEC_RESET;
    assign o_handler_mode = r.handler_mode;
    assign o_privileged = r.privileged;

    // reserved numbers 7 to 10, 12 and 13 never pend; of them 7, 12 and 13 never activate
    property p_reserved_idle;
        @(posedge i_mclk) disable iff (i_reset)
        (r.pend[7] | r.pend[8] | r.pend[9] | r.pend[10] | r.pend[12] | r.pend[13]
         | r.act[7] | r.act[12] | r.act[13]) == 1'b0;
    endproperty
    a_reserved_idle: assert property (p_reserved_idle) else $error("reserved exception set");

    // a peripheral request shows pending next cycle
    property p_irq_pends;
        @(posedge i_mclk) disable iff (i_reset)
        (r.phase == PH_RUN) && i_irq[0] |=> r.pend[EXC_IRQ0];
    endproperty
    a_irq_pends: assert property (p_irq_pends) else $error("irq not pending");

    // entry while a handler runs keeps both active
    property p_nested;
        @(posedge i_mclk) disable iff (i_reset)
        enter_now && (r.act != '0) && !i_return |=> $countones(r.act) >= 2;
    endproperty
    a_nested: assert property (p_nested) else $error("nesting lost an active");

    // same source requesting at entry ends active and pending
    property p_act_and_pend;
        @(posedge i_mclk) disable iff (i_reset)
        enter_now && (int'(r.take_num) == EXC_IRQ0) && i_irq[0] |=>
            r.act[EXC_IRQ0] && r.pend[EXC_IRQ0];
    endproperty
    a_act_and_pend: assert property (p_act_and_pend) else $error("not active and pending");

    // the first run cycle after reset fetches the vector in clean privileged thread
    property p_after_reset;
        @(posedge i_mclk) disable iff (i_reset)
        $rose(r.phase == PH_RUN) |-> o_fetch_valid && (o_fetch_addr == VEC_RESET)
            && (r.act == '0) && (r.pend == '0) && !o_take_valid
            && o_privileged && !o_handler_mode;
    endproperty
    a_after_reset: assert property (p_after_reset) else $error("bad reset restart");

    // nmi raised in thread mode is offered within a few cycles unless already active
    property p_nmi_taken;
        @(posedge i_mclk) disable iff (i_reset)
        (r.phase == PH_RUN) && i_nmi_req && !r.act[EXC_NMI] && (r.exc_number == '0) |->
            ##[1:4] (o_take_valid && int'(o_take_num) == EXC_NMI) || r.act[EXC_NMI];
    endproperty
    a_nmi_taken: assert property (p_nmi_taken) else $error("nmi not offered");

    // processing error raises hard fault
    property p_hard;
        @(posedge i_mclk) disable iff (i_reset)
        (r.phase == PH_RUN) && i_proc_err |=> r.pend[EXC_HARD] || r.act[EXC_HARD];
    endproperty
    a_hard: assert property (p_hard) else $error("hard fault missing");

    // supervisor call raises 11 or escalates
    property p_super_call;
        @(posedge i_mclk) disable iff (i_reset)
        (r.phase == PH_RUN) && i_supervisor_call |=> r.pend[EXC_SUPER_CALL] || r.pend[EXC_HARD];
    endproperty
    a_super_call: assert property (p_super_call) else $error("supervisor call lost");

    // offered vector is four times the number and never a reserved number
    property p_vec;
        @(posedge i_mclk) disable iff (i_reset)
        o_take_valid |-> (o_take_vec == {{(30 - NW){1'b0}}, o_take_num, 2'b00})
            && !is_reserved(int'(o_take_num));
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector offer");

    // unprivileged enable writes change nothing
    property p_priv_en;
        @(posedge i_mclk) disable iff (i_reset)
        i_en_wr && !i_privileged |=> r.en == $past(r.en);
    endproperty
    a_priv_en: assert property (p_priv_en) else $error("unprivileged disable");

    // main scenarios
    c_nested: cover property (@(posedge i_mclk) disable iff (i_reset) $countones(r.act) >= 2);
    c_act_pend: cover property (@(posedge i_mclk) disable iff (i_reset) |(r.act & r.pend));
    c_nmi: cover property (@(posedge i_mclk) disable iff (i_reset) r.act[EXC_NMI]);
    c_hard: cover property (@(posedge i_mclk) disable iff (i_reset) r.act[EXC_HARD]);
endmodule : exc_unit
